//--- rmon_stat_bank.sv
// Ethernet monitoring statistics counter bank on the memory window
`timescale 1ns/10ps
module rmon_stat_bank
    import rmon_stat_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    // Host access, already decoded against the memory window base
    input wire logic HOST_SEL_I,
    input wire logic HOST_MEM_SPACE_I,
    input wire logic HOST_WR_I,
    input wire logic [ADDR_W-1:0] HOST_ADDR_I,
    input wire logic [CNT_W-1:0] HOST_WDATA_I,
    output logic [CNT_W-1:0] HOST_RDATA_O,
    output logic HOST_HIT_O,
    // Control bits from the MAC control and mask registers
    input wire logic STATS_GLOBAL_ENABLE_I,
    input wire logic [NUM_CNT-1:0] MONITOR_COUNTER_MASK_I,
    // Event reports from the MAC, one cycle each
    input wire logic COLLISION_I,
    input wire logic RX_DONE_I,
    input wire logic RX_FCS_BAD_I,
    input wire logic [15:0] RX_LEN_I,
    input wire logic TX_DONE_I,
    input wire logic [15:0] TX_LEN_I,
    // One-cycle request to set the harvest flag in the interrupt status register
    output logic STATS_HARVEST_FLAG_O
);
    logic [NUM_CNT-1:0] event_v;
    logic [NUM_CNT-1:0] enable_v;
    logic [NUM_CNT-1:0] write_v;
    logic [NUM_CNT-1:0] hit_v;
    logic [NUM_CNT-1:0] addr_match_v;
    logic [NUM_CNT-1:0] read_v;
    logic [CNT_W-1:0] step_v [NUM_CNT];
    logic [CNT_W-1:0] value_v [NUM_CNT];
    logic [ADDR_W-1:0] offs_v [NUM_CNT];
    logic host_mem_acc;
    logic rx_short;
    logic rx_long;
    logic rx_bad_done;
    logic [CNT_W-1:0] rdata_nxt;
    logic hit_nxt;

    // Host access notes:
    //   a strobe with the memory-space qualifier is the only way in
    //   I/O-space cycles are dropped here, so the I/O window never reaches a counter
    //   a write lands on the edge that takes it; a read answers one edge later
    //   read data and hit stand for one cycle and then return to zero
    //   unmapped offsets give no write and a zero read with hit low
    // I/O-space cycles never reach this bank
    assign host_mem_acc = HOST_SEL_I && HOST_MEM_SPACE_I;

    // Limitations:
    //   event inputs are same-clock pulses from the MAC, so no synchroniser is used
    //   the drop, oversize, broadcast and multicast objects are not counted here
    //   reset clears every counter to zero; there is no clear-on-read

    // Counter map, index equals mask bit:
    //   0 collisions, 0x100, one per collision report
    //   1 tx octets, 0x104, adds the transmitted length
    //   2 tx frames, 0x108, one per transmitted frame
    //   3 tx minimum frames, 0x10C, transmitted frames of exactly 64 octets
    //   4 crc/align errors, 0x124, bad FCS from 64 to 1518 octets
    //   5 fragments, 0x128, bad FCS under 64 octets
    //   6 jabbers, 0x130, bad FCS over 1518 octets
    //   7 rx octets, 0x134, adds the received length
    //   8 rx frames, 0x138, one per received frame
    //   9 rx minimum frames, 0x13C, received frames of exactly 64 octets
    // Fixed offset table
    assign offs_v[MSK_COLLISION] = OFS_COLLISION;
    assign offs_v[MSK_TX_OCTET] = OFS_TX_OCTET;
    assign offs_v[MSK_TX_FRAME] = OFS_TX_FRAME;
    assign offs_v[MSK_TX_MIN_FRAME] = OFS_TX_MIN_FRAME;
    assign offs_v[MSK_CRC_ALIGN] = OFS_CRC_ALIGN;
    assign offs_v[MSK_FRAGMENT] = OFS_FRAGMENT;
    assign offs_v[MSK_RX_JABBER] = OFS_RX_JABBER;
    assign offs_v[MSK_RX_OCTET] = OFS_RX_OCTET;
    assign offs_v[MSK_RX_FRAME] = OFS_RX_FRAME;
    assign offs_v[MSK_RX_MIN_FRAME] = OFS_RX_MIN_FRAME;

    // Length classes of the received frame
    assign rx_short = RX_LEN_I < MIN_FRAME_LEN;
    assign rx_long = RX_LEN_I > MAX_FRAME_LEN;
    // Lengths include the FCS; both 64 and 1518 fall in the middle class
    // A partial final octet arrives as a bad FCS like any other FCS error
    assign rx_bad_done = RX_DONE_I && RX_FCS_BAD_I;

    // Qualifying events per counter
    assign event_v[MSK_COLLISION] = COLLISION_I;
    assign event_v[MSK_TX_OCTET] = TX_DONE_I;
    assign event_v[MSK_TX_FRAME] = TX_DONE_I;
    assign event_v[MSK_TX_MIN_FRAME] = TX_DONE_I && (TX_LEN_I == MIN_FRAME_LEN);
    assign event_v[MSK_CRC_ALIGN] = rx_bad_done && !rx_short && !rx_long;
    assign event_v[MSK_FRAGMENT] = rx_bad_done && rx_short;
    assign event_v[MSK_RX_JABBER] = rx_bad_done && rx_long;
    assign event_v[MSK_RX_OCTET] = RX_DONE_I;
    assign event_v[MSK_RX_FRAME] = RX_DONE_I;
    assign event_v[MSK_RX_MIN_FRAME] = RX_DONE_I && (RX_LEN_I == MIN_FRAME_LEN);

    // Step sizes: octet counters add the length, others add one
    assign step_v[MSK_COLLISION] = 32'h00000001;
    assign step_v[MSK_TX_OCTET] = {16'h0000, TX_LEN_I};
    assign step_v[MSK_TX_FRAME] = 32'h00000001;
    assign step_v[MSK_TX_MIN_FRAME] = 32'h00000001;
    assign step_v[MSK_CRC_ALIGN] = 32'h00000001;
    assign step_v[MSK_FRAGMENT] = 32'h00000001;
    assign step_v[MSK_RX_JABBER] = 32'h00000001;
    assign step_v[MSK_RX_OCTET] = {16'h0000, RX_LEN_I};
    assign step_v[MSK_RX_FRAME] = 32'h00000001;
    assign step_v[MSK_RX_MIN_FRAME] = 32'h00000001;

    // Drop, oversize, broadcast and multicast stay in the general counters elsewhere

    // Counting notes:
    //   an event counts only with the global enable high and its mask bit low
    //   a host write in the same cycle as an event wins; that increment is lost
    //   octet counters step by the frame length and may jump over the threshold
    //   every counter wraps modulo 2^32 with no saturation
    //   the harvest request fires once per crossing, not while the count stays high
    // One counter cell per object
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            assign enable_v[gi] = event_v[gi] && STATS_GLOBAL_ENABLE_I
                && !MONITOR_COUNTER_MASK_I[gi];
            assign addr_match_v[gi] = host_mem_acc && (HOST_ADDR_I == offs_v[gi]);
            assign write_v[gi] = addr_match_v[gi] && HOST_WR_I;
            assign read_v[gi] = addr_match_v[gi] && !HOST_WR_I;
            rmon_stat_cell #(
                .W(CNT_W)
            ) rmon_stat_cell_i (
                .REF_CLK_I(REF_CLK_I),
                .NRST_I(NRST_I),
                .count_en_i(enable_v[gi]),
                .step_i(step_v[gi]),
                .wr_i(write_v[gi]),
                .wr_data_i(HOST_WDATA_I),
                .value_o(value_v[gi]),
                .hit_o(hit_v[gi])
            );
        end
    endgenerate

    // Any counter crossing the threshold raises the harvest request
    // The status register lives outside; several crossings in one cycle give one pulse
    assign STATS_HARVEST_FLAG_O = |hit_v;

    // Read multiplexer; unmapped or I/O reads give the idle value
    always_comb begin
        rdata_nxt = RD_IDLE;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (read_v[i]) begin
                rdata_nxt = value_v[i];
            end
        end
    end

    // Hit only for a memory-space read of a mapped counter
    assign hit_nxt = |read_v;

    // Registered read answer, standing one cycle
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            HOST_RDATA_O <= RD_IDLE;
            HOST_HIT_O <= 1'b0;
        end else begin
            HOST_RDATA_O <= rdata_nxt;
            HOST_HIT_O <= hit_nxt;
        end
    end
endmodule

//--- rmon_stat_bank_monitor.sv
// Port-level checks of the statistics counter bank
`timescale 1ns/10ps
module rmon_stat_bank_monitor
    import rmon_stat_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic HOST_SEL_I,
    input wire logic HOST_MEM_SPACE_I,
    input wire logic HOST_WR_I,
    input wire logic [ADDR_W-1:0] HOST_ADDR_I,
    input wire logic [CNT_W-1:0] HOST_WDATA_I,
    input wire logic [CNT_W-1:0] HOST_RDATA_O,
    input wire logic HOST_HIT_O,
    input wire logic STATS_GLOBAL_ENABLE_I,
    input wire logic [NUM_CNT-1:0] MONITOR_COUNTER_MASK_I,
    input wire logic COLLISION_I,
    input wire logic RX_DONE_I,
    input wire logic TX_DONE_I,
    input wire logic STATS_HARVEST_FLAG_O
);
    logic mapped;
    logic rd;
    logic wr;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // Host access decode
    assign mapped = HOST_ADDR_I inside {OFS_COLLISION, OFS_TX_OCTET, OFS_TX_FRAME, OFS_TX_MIN_FRAME,
        OFS_CRC_ALIGN, OFS_FRAGMENT, OFS_RX_JABBER, OFS_RX_OCTET, OFS_RX_FRAME, OFS_RX_MIN_FRAME};
    assign rd = HOST_SEL_I && HOST_MEM_SPACE_I && !HOST_WR_I;
    assign wr = HOST_SEL_I && HOST_MEM_SPACE_I && HOST_WR_I;
    // Write then immediate read of the same counter
    sequence wr_rd_s;
        wr && mapped ##1 rd && HOST_ADDR_I == $past(HOST_ADDR_I);
    endsequence
    chk_read_hit: assert property (rd && mapped |=> HOST_HIT_O)
        else $error("counter read without hit");
    chk_io_refused: assert property (HOST_SEL_I && !HOST_MEM_SPACE_I |=> !HOST_HIT_O)
        else $error("io access answered");
    chk_unmapped_zero: assert property (HOST_SEL_I && !mapped |=> !HOST_HIT_O)
        else $error("unmapped access answered");
    chk_idle_zero: assert property (!HOST_HIT_O |-> HOST_RDATA_O == RD_IDLE)
        else $error("read data not idle");
    chk_write_readback: assert property (wr_rd_s |=> HOST_RDATA_O == $past(HOST_WDATA_I, 2))
        else $error("written value not read back");
    chk_harvest_cause: assert property (STATS_HARVEST_FLAG_O |->
        $past(STATS_GLOBAL_ENABLE_I && (COLLISION_I || RX_DONE_I || TX_DONE_I)))
        else $error("harvest without counted event");
    chk_disabled_silent: assert property (!STATS_GLOBAL_ENABLE_I |=> !STATS_HARVEST_FLAG_O)
        else $error("harvest while disabled");
    chk_masked_silent: assert property (COLLISION_I && MONITOR_COUNTER_MASK_I[MSK_COLLISION]
        && !RX_DONE_I && !TX_DONE_I |=> !STATS_HARVEST_FLAG_O)
        else $error("masked collision counted");
endmodule
bind rmon_stat_bank rmon_stat_bank_monitor rmon_stat_bank_monitor_i (.*);

//--- rmon_stat_cell.sv
// One statistics counter with host write, gated increment and threshold detect
`timescale 1ns/10ps
module rmon_stat_cell
    import rmon_stat_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic count_en_i,
    input wire logic [W-1:0] step_i,
    input wire logic wr_i,
    input wire logic [W-1:0] wr_data_i,
    output logic [W-1:0] value_o,
    output logic hit_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Increment wraps modulo 2^W; a host write takes precedence
    always_comb begin
        cnt_nxt = cnt_r + step_i;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            cnt_r <= W'(CNT_RESET);
        end else if (wr_i) begin
            cnt_r <= wr_data_i;
        end else if (count_en_i) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Pulse when an increment reaches or passes the threshold
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= count_en_i && !wr_i && (cnt_r < W'(HARVEST_LEVEL))
                && (cnt_nxt >= W'(HARVEST_LEVEL));
        end
    end

    assign value_o = cnt_r;
endmodule

//--- rmon_stat_pkg.sv
// Package of offsets, mask bit positions and constants for the statistics counter bank
package rmon_stat_pkg;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 12;
    // Memory window byte offsets of the dedicated counters
    localparam logic [11:0] OFS_COLLISION = 12'h100;
    localparam logic [11:0] OFS_TX_OCTET = 12'h104;
    localparam logic [11:0] OFS_TX_FRAME = 12'h108;
    localparam logic [11:0] OFS_TX_MIN_FRAME = 12'h10C;
    localparam logic [11:0] OFS_CRC_ALIGN = 12'h124;
    localparam logic [11:0] OFS_FRAGMENT = 12'h128;
    localparam logic [11:0] OFS_RX_JABBER = 12'h130;
    localparam logic [11:0] OFS_RX_OCTET = 12'h134;
    localparam logic [11:0] OFS_RX_FRAME = 12'h138;
    localparam logic [11:0] OFS_RX_MIN_FRAME = 12'h13C;
    // Mask register bit positions, one per counter
    localparam int NUM_CNT = 10;
    localparam int MSK_COLLISION = 0;
    localparam int MSK_TX_OCTET = 1;
    localparam int MSK_TX_FRAME = 2;
    localparam int MSK_TX_MIN_FRAME = 3;
    localparam int MSK_CRC_ALIGN = 4;
    localparam int MSK_FRAGMENT = 5;
    localparam int MSK_RX_JABBER = 6;
    localparam int MSK_RX_OCTET = 7;
    localparam int MSK_RX_FRAME = 8;
    localparam int MSK_RX_MIN_FRAME = 9;
    // Frame length limits in octets, FCS included
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
    localparam logic [15:0] MAX_FRAME_LEN = 16'h05EE;
    // Threshold that requests a harvest of the counters
    localparam logic [31:0] HARVEST_LEVEL = 32'h0000C000;
    localparam logic [31:0] CNT_RESET = 32'h00000000;
    localparam logic [31:0] RD_IDLE = 32'h00000000;
endpackage

//--- tb_rmon_stat_bank.sv
// Self-checking bench of the statistics counter bank
`timescale 1ns/10ps
module tb_rmon_stat_bank;
    import rmon_stat_pkg::*;
    logic REF_CLK_I = 0, NRST_I = 0, HOST_SEL_I = 0, HOST_MEM_SPACE_I = 0, HOST_WR_I = 0;
    logic STATS_GLOBAL_ENABLE_I = 1, COLLISION_I = 0, RX_DONE_I = 0, RX_FCS_BAD_I = 0, TX_DONE_I = 0;
    logic [11:0] HOST_ADDR_I = 0;
    logic [31:0] HOST_WDATA_I = 0, HOST_RDATA_O;
    logic [9:0] MONITOR_COUNTER_MASK_I = 0;
    logic [15:0] RX_LEN_I = 0, TX_LEN_I = 0, lfsr = 16'hA876;
    logic HOST_HIT_O, STATS_HARVEST_FLAG_O, rd_q = 0;
    logic [32:0] expq[$];
    logic [11:0] ofs[10] = '{OFS_COLLISION, OFS_TX_OCTET, OFS_TX_FRAME, OFS_TX_MIN_FRAME,
        OFS_CRC_ALIGN, OFS_FRAGMENT, OFS_RX_JABBER, OFS_RX_OCTET, OFS_RX_FRAME, OFS_RX_MIN_FRAME};
    int miscompares = 0, samples_checked = 0, harvests = 0;
    rmon_stat_bank rmon_stat_bank_i (.*);
    // Free-running clock
    initial begin
        forever #5 REF_CLK_I = ~REF_CLK_I;
    end
    // Pseudo-random data source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_harvest(input int got, input int exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One host cycle; a read notes its expected hit and data
    task automatic acc(input logic s, m, w, input logic [11:0] a, input logic [32:0] d);
        HOST_SEL_I <= s;
        HOST_MEM_SPACE_I <= m;
        HOST_WR_I <= w;
        HOST_ADDR_I <= a;
        HOST_WDATA_I <= d[31:0];
        if (s && !w) expq.push_back(d);
        @(posedge REF_CLK_I);
    endtask
    // One cycle of MAC event reports
    task automatic ev(input logic c, r, t, b, input logic [15:0] len);
        COLLISION_I <= c;
        RX_DONE_I <= r;
        TX_DONE_I <= t;
        RX_FCS_BAD_I <= b;
        RX_LEN_I <= len;
        TX_LEN_I <= len;
        @(posedge REF_CLK_I);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Result watcher: read answers and harvest pulses
    always @(posedge REF_CLK_I) begin
        rd_q <= HOST_SEL_I && !HOST_WR_I;
        if (STATS_HARVEST_FLAG_O === 1'b1) harvests <= harvests + 1;
        if (rd_q) cmp({HOST_HIT_O, HOST_RDATA_O}, expq.pop_front());
    end
    // Watchdog
    initial begin
        #5000;
        miscompares++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge REF_CLK_I);
        NRST_I <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            lfsr = lfsr_next(lfsr);
            acc(1, 1, 0, ofs[i], {1'b1, CNT_RESET});
            acc(1, 1, 1, ofs[i], {1'b0, lfsr, ~lfsr});
            acc(1, 1, 0, ofs[i], {1'b1, lfsr, ~lfsr});
            acc(1, 1, 1, ofs[i], 33'h0);
        end
        acc(1, 1, 1, OFS_COLLISION, 33'h00000BFFE);
        acc(1, 0, 1, OFS_COLLISION, 33'h5);
        acc(1, 0, 0, OFS_COLLISION, {1'b0, RD_IDLE});
        acc(1, 1, 0, 12'h12C, {1'b0, RD_IDLE});
        acc(1, 1, 1, OFS_RX_OCTET, 33'hFFFFFFF0);
        acc(0, 0, 0, 12'h0, 33'h0);
        MONITOR_COUNTER_MASK_I <= 10'h001;
        ev(1, 0, 0, 0, 16'h0000);
        MONITOR_COUNTER_MASK_I <= 10'h000;
        STATS_GLOBAL_ENABLE_I <= 1'b0;
        ev(1, 0, 0, 0, 16'h0000);
        STATS_GLOBAL_ENABLE_I <= 1'b1;
        ev(1, 0, 0, 0, 16'h0000);
        ev(0, 1, 0, 1, 16'h003F);
        ev(1, 1, 0, 1, 16'h0040);
        ev(0, 1, 1, 1, 16'h05EE);
        ev(0, 1, 0, 1, 16'h05EF);
        ev(0, 1, 0, 0, 16'h05EF);
        ev(0, 0, 1, 0, 16'h0040);
        ev(0, 0, 0, 0, 16'h0000);
        acc(1, 1, 0, OFS_COLLISION, {1'b1, HARVEST_LEVEL});
        acc(1, 1, 0, OFS_FRAGMENT, 33'h100000001);
        acc(1, 1, 0, OFS_CRC_ALIGN, 33'h100000002);
        acc(1, 1, 0, OFS_RX_JABBER, 33'h100000001);
        acc(1, 1, 0, OFS_RX_OCTET, 33'h10000123B);
        acc(1, 1, 0, OFS_TX_OCTET, 33'h10000062E);
        acc(1, 1, 0, OFS_TX_FRAME, 33'h100000002);
        acc(1, 1, 0, OFS_TX_MIN_FRAME, 33'h100000001);
        acc(1, 1, 0, OFS_RX_FRAME, 33'h100000005);
        acc(1, 1, 0, OFS_RX_MIN_FRAME, 33'h100000001);
        acc(0, 0, 0, 12'h0, 33'h0);
        repeat (3) @(posedge REF_CLK_I);
        cmp_harvest(harvests, 1);
        complete_run();
    end
endmodule
